// >>> core/i2c_master_tx.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_tx (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe
);
  // Sequencer state and line samplers
  i2c_tx_pkg::state_t state_q;
  logic [2:0] sda_sync_q;
  logic [2:0] scl_sync_q;
  logic       sda_q;
  logic       scl_q;

  // Baud generator, data path and bit position
  logic [7:0] baud_q;
  logic [7:0] cnt_q;
  logic [7:0] buf_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;

  // Software-visible request and status bits
  logic       start_req_q;
  logic       restart_req_q;
  logic       stop_req_q;
  logic       ack_stat_q;
  logic       buf_full_q;
  logic       start_det_q;
  logic       write_collision_flag_q;
  logic       bcol_q;
  logic       event_q;

  // Open-drain drive requests; high pulls the line low
  logic       sda_low_q;
  logic       scl_low_q;

  // Decoded strobes; all but rd_acc and start_fall are shared by several processes
  logic       timeout;
  logic       wr_acc;
  logic       rd_acc;
  logic       busy;
  logic       start_fall;

  // Open-drain lines: the data level is always low, only the enable moves.
  // Driving high would fight a slave that stretches SCL or answers on SDA.
  assign sda_oe  = sda_low_q;
  assign scl_oe  = scl_low_q;

  // Zero-wait APB slave; every access completes in its first access cycle.
  // The fixed levels still come from flip-flops so no output is combinational.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // Writes need the access phase; reads are captured in the setup cycle
  assign wr_acc  = psel && penable && pwrite && clk_en;
  assign rd_acc  = psel && !pwrite;
  assign busy    = (state_q != i2c_tx_pkg::S_IDLE);
  assign timeout = (cnt_q == 8'h00);

  // Three-stage sampling; a change counts once stages two and three agree.
  // The first stage may go metastable, so only the later stages are read.
  // Costs four cycles of latency on every line edge the sequencer sees.
  // Lines reset high, matching the idle bus, so no false edge follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_q <= 3'h7;
      scl_sync_q <= 3'h7;
      sda_q      <= 1'b1;
      scl_q      <= 1'b1;
    end else if (clk_en) begin
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
      if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
    end
  end

  // SDA falling while SCL high is a Start seen on the lines
  // Looks one stage ahead so the flag rises with the filtered fall
  assign start_fall = sda_q && (sda_sync_q[1] == sda_sync_q[2]) && !sda_sync_q[2] && scl_q;

  // Read mux is registered so prdata comes from a flip-flop
  // Captured in the setup cycle; it stands until the next read setup
  // Unmapped offsets read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && rd_acc && !penable) begin
      unique case (paddr)
        i2c_tx_pkg::ADDR_CTRL:   prdata <= {25'h0, ack_stat_q, 3'h0, stop_req_q,
                                            restart_req_q, start_req_q};
        i2c_tx_pkg::ADDR_STATUS: prdata <= {26'h0, busy, event_q, bcol_q, write_collision_flag_q,
                                            start_det_q, buf_full_q};
        i2c_tx_pkg::ADDR_BUF:    prdata <= {24'h0, buf_q};
        i2c_tx_pkg::ADDR_BAUD:   prdata <= {24'h0, baud_q};
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Baud reload value register
  // A new value only takes effect at the next reload of the generator
  // Writable at any time; a change mid-byte alters the following bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_q <= i2c_tx_pkg::BAUD_RESET;
    end else if (wr_acc && paddr == i2c_tx_pkg::ADDR_BAUD) begin
      baud_q <= pwdata[7:0];
    end
  end

  // Sticky status flags; hardware set wins over a software clear.
  // The clears sit above the sets in this process, so a flag that is
  // raised in the same cycle as its clear stays raised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision_flag_q      <= 1'b0;
      bcol_q      <= 1'b0;
      event_q     <= 1'b0;
      start_det_q <= 1'b0;
    end else if (clk_en) begin
      // Software clears with a one in the bit position
      if (wr_acc && paddr == i2c_tx_pkg::ADDR_STATUS) begin
        if (pwdata[i2c_tx_pkg::ST_WRITE_COLLISION_FLAG])      write_collision_flag_q      <= 1'b0;
        if (pwdata[i2c_tx_pkg::ST_BCOL])      bcol_q      <= 1'b0;
        if (pwdata[i2c_tx_pkg::ST_EVENT])     event_q     <= 1'b0;
        if (pwdata[i2c_tx_pkg::ST_START_DET]) start_det_q <= 1'b0;
      end

      // A buffer write that cannot be taken is reported, never queued
      if (wr_acc && paddr == i2c_tx_pkg::ADDR_BUF && busy) write_collision_flag_q <= 1'b1;
      // Start seen on the lines, ours or another master's
      if (start_fall) start_det_q <= 1'b1;

      // Collision and event sources, listed by sequencer state
      unique case (state_q)
        i2c_tx_pkg::S_IDLE: begin
          // Both lines already low when a Start is asked for
          if (start_req_q && !sda_q && !scl_q) bcol_q <= 1'b1;
        end
        i2c_tx_pkg::S_ST_WAIT: begin
          // SDA is not driven yet, so a low SCL belongs to someone else
          if (!scl_q) bcol_q <= 1'b1;
        end
        i2c_tx_pkg::S_ST_HOLD: begin
          // Start complete once the second period runs out
          if (timeout) event_q <= 1'b1;
        end
        i2c_tx_pkg::S_RS_SCLHI: begin
          // SDA must already be high when SCL comes up
          if (scl_q && !sda_q) bcol_q <= 1'b1;
        end
        i2c_tx_pkg::S_RS_SDAHI: begin
          // Released SDA still low at timeout: another driver holds it
          if (timeout && !sda_q) bcol_q <= 1'b1;
        end
        i2c_tx_pkg::S_RS_SDALO: begin
          // SCL may not fall before our SDA low; the event waits for the
          // period that follows the Start on the lines
          if (!scl_q && !sda_low_q) bcol_q <= 1'b1;
          else if (timeout && sda_low_q) event_q <= 1'b1;
        end
        i2c_tx_pkg::S_TX_HIGH: begin
          // Event only after the acknowledge clock
          if (timeout && bit_q == i2c_tx_pkg::LAST_BIT) event_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Main sequencer: Start, Repeated Start and byte transmit.
  // Every wait on a released SCL parks the generator, so a slow peer
  // stretches the bus without shortening our own high or low times.
  // Stop is stored but never generated; software ends with a Restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= i2c_tx_pkg::S_IDLE;
      cnt_q         <= 8'h00;
      buf_q         <= 8'h00;
      shift_q       <= 8'h00;
      bit_q         <= 4'h0;
      start_req_q   <= 1'b0;
      restart_req_q <= 1'b0;
      stop_req_q    <= 1'b0;
      ack_stat_q    <= 1'b0;
      buf_full_q    <= 1'b0;
      sda_low_q     <= 1'b0;
      scl_low_q     <= 1'b0;
    end else if (clk_en) begin
      // Generator counts down and parks at zero until reloaded
      if (!timeout) cnt_q <= cnt_q - 8'h01;
      // Requests are accepted only while idle; no queuing
      if (wr_acc && paddr == i2c_tx_pkg::ADDR_CTRL && !busy) begin
        start_req_q   <= pwdata[i2c_tx_pkg::BIT_START_REQ];
        restart_req_q <= pwdata[i2c_tx_pkg::BIT_RESTART_REQ];
        stop_req_q    <= pwdata[i2c_tx_pkg::BIT_STOP_REQ];
      end
      unique case (state_q)
        // Idle: a request or a buffer write starts the next sequence
        i2c_tx_pkg::S_IDLE: begin
          if (start_req_q) begin
            if (!sda_q && !scl_q) begin
              start_req_q <= 1'b0;
            end else begin
              cnt_q   <= baud_q;
              state_q <= i2c_tx_pkg::S_ST_WAIT;
            end
          end else if (restart_req_q) begin
            // Restart opens by pulling SCL low
            scl_low_q <= 1'b1;
            state_q   <= i2c_tx_pkg::S_RS_SCLLO;
          end else if (wr_acc && paddr == i2c_tx_pkg::ADDR_BUF) begin
            // Byte accepted: SCL goes low at once and the first bit follows
            buf_q      <= pwdata[7:0];
            shift_q    <= pwdata[7:0];
            buf_full_q <= 1'b1;
            bit_q      <= 4'h0;
            scl_low_q  <= 1'b1;
            cnt_q      <= baud_q;
            state_q    <= i2c_tx_pkg::S_TX_LOW;
          end
        end

        // Start, first period: both lines must stay high
        i2c_tx_pkg::S_ST_WAIT: begin
          if (!scl_q) begin
            start_req_q <= 1'b0;
            sda_low_q   <= 1'b0;
            state_q     <= i2c_tx_pkg::S_IDLE;
          end else if (timeout && sda_q) begin
            sda_low_q <= 1'b1;
            cnt_q     <= baud_q;
            state_q   <= i2c_tx_pkg::S_ST_HOLD;
          end
        end

        // Start, second period: SDA held low, then back to idle
        i2c_tx_pkg::S_ST_HOLD: begin
          if (timeout) begin
            start_req_q <= 1'b0;
            state_q     <= i2c_tx_pkg::S_IDLE;
          end
        end

        // Restart: wait until SCL is really low before releasing SDA
        i2c_tx_pkg::S_RS_SCLLO: begin
          if (!scl_q) begin
            sda_low_q <= 1'b0;
            cnt_q     <= baud_q;
            state_q   <= i2c_tx_pkg::S_RS_SDAHI;
          end
        end

        // Restart: SDA released for one period with SCL low
        i2c_tx_pkg::S_RS_SDAHI: begin
          if (timeout) begin
            if (sda_q) begin
              scl_low_q <= 1'b0;
              state_q   <= i2c_tx_pkg::S_RS_SCLHI;
            end else begin
              restart_req_q <= 1'b0;
              scl_low_q     <= 1'b0;
              state_q       <= i2c_tx_pkg::S_IDLE;
            end
          end
        end

        // Restart: SCL released, arbitration wait
        i2c_tx_pkg::S_RS_SCLHI: begin
          // Generator frozen until SCL is seen high
          if (scl_q) begin
            if (!sda_q) begin
              restart_req_q <= 1'b0;
              state_q       <= i2c_tx_pkg::S_IDLE;
            end else begin
              cnt_q   <= baud_q;
              state_q <= i2c_tx_pkg::S_RS_SDALO;
            end
          end else begin
            cnt_q <= cnt_q;
          end
        end

        // Restart: both high for one period, then SDA low for one more
        i2c_tx_pkg::S_RS_SDALO: begin
          if (!scl_q && !sda_low_q) begin
            restart_req_q <= 1'b0;
            state_q       <= i2c_tx_pkg::S_IDLE;
          end else if (timeout) begin
            if (sda_low_q) begin
              scl_low_q     <= 1'b1;
              restart_req_q <= 1'b0;
              state_q       <= i2c_tx_pkg::S_IDLE;
            end else begin
              sda_low_q <= 1'b1;
              cnt_q     <= baud_q;
            end
          end
        end

        // Transmit: SCL low half of a bit
        i2c_tx_pkg::S_TX_LOW: begin
          // SDA changes while SCL is low, MSB first
          if (bit_q == i2c_tx_pkg::LAST_BIT) begin
            sda_low_q <= 1'b0;
          end else begin
            sda_low_q <= !shift_q[7];
          end
          if (timeout) begin
            scl_low_q <= 1'b0;
            state_q   <= i2c_tx_pkg::S_TX_RISE;
          end
        end

        // Transmit: SCL released, wait for a stretching peer to let go
        i2c_tx_pkg::S_TX_RISE: begin
          if (scl_q) begin
            cnt_q   <= baud_q;
            state_q <= i2c_tx_pkg::S_TX_HIGH;
            if (bit_q == i2c_tx_pkg::LAST_BIT) ack_stat_q <= sda_q;
          end else begin
            cnt_q <= cnt_q;
          end
        end

        // Transmit: SCL high half of a bit
        i2c_tx_pkg::S_TX_HIGH: begin
          if (timeout) begin
            scl_low_q <= 1'b1;
            cnt_q     <= baud_q;
            if (bit_q == i2c_tx_pkg::LAST_BIT) begin
              // Acknowledge clock done: park with SCL low and SDA free
              state_q   <= i2c_tx_pkg::S_IDLE;
              sda_low_q <= 1'b0;
            end else begin
              // Next bit; buffer empties on the eighth falling edge
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q   <= bit_q + 4'h1;
              if (bit_q == 4'h7) buf_full_q <= 1'b0;
              state_q <= i2c_tx_pkg::S_TX_LOW;
            end
          end
        end

        // Unused codes fall back to idle
        default: state_q <= i2c_tx_pkg::S_IDLE;
      endcase
    end
  end
endmodule : i2c_master_tx
`default_nettype wire

// >>> shared/i2c_tx_pkg.sv
package i2c_tx_pkg;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;  // second_control_register
  localparam logic [11:0] ADDR_STATUS = 12'h004;  // port_status_register
  localparam logic [11:0] ADDR_BUF    = 12'h008;  // transfer_buffer
  localparam logic [11:0] ADDR_BAUD   = 12'h00C;  // baud_reload_value
  localparam int BIT_START_REQ   = 0;
  localparam int BIT_RESTART_REQ = 1;
  localparam int BIT_STOP_REQ    = 2;
  localparam int BIT_ACK_STAT    = 6;
  localparam int ST_BUF_FULL   = 0;
  localparam int ST_START_DET  = 1;
  localparam int ST_WRITE_COLLISION_FLAG       = 2;
  localparam int ST_BCOL       = 3;
  localparam int ST_EVENT      = 4;
  localparam int ST_BUSY       = 5;
  localparam logic [7:0] BAUD_RESET = 8'h09;
  localparam logic [3:0] LAST_BIT   = 4'h8;   // Bit index of the ack slot
  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_ST_WAIT  = 4'b0001,
    S_ST_HOLD  = 4'b0010,
    S_RS_SCLLO = 4'b0011,
    S_RS_SDAHI = 4'b0100,
    S_RS_SCLHI = 4'b0101,
    S_RS_SDALO = 4'b0110,
    S_TX_LOW   = 4'b0111,
    S_TX_RISE  = 4'b1000,
    S_TX_HIGH  = 4'b1001
  } state_t;
endpackage : i2c_tx_pkg

// >>> verif/i2c_master_tx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_tx_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sda_in,
  input wire logic        scl_in,
  input wire logic        sda_oe,
  input wire logic        scl_oe
);
  logic [7:0] baud_q, hi_q, lo_q, both_q, nf_q;
  // Shadow of the reload value, so the SCL high, SCL low and start lead bounds follow what software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      baud_q <= i2c_tx_pkg::BAUD_RESET;
    else if (psel && penable && pwrite && clk_en &&
             paddr == i2c_tx_pkg::ADDR_BAUD)
      baud_q <= pwdata[7:0];
  end
  // Saturating run lengths of line and drive levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q   <= 8'h00;
      lo_q   <= 8'h00;
      both_q <= 8'h00;
    end else begin
      hi_q   <= scl_in ? hi_q + 8'(hi_q != 8'hFF) : 8'h00;
      lo_q   <= scl_oe ? lo_q + 8'(lo_q != 8'hFF) : 8'h00;
      both_q <= (scl_in && sda_in) ? both_q + 8'(both_q != 8'hFF) : 8'h00;
    end
  end
  // SCL falls since the last start seen on the lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      nf_q <= 8'h00;
    else if ($fell(sda_in) && scl_in)
      nf_q <= 8'h00;
    else if ($fell(scl_in))
      nf_q <= nf_q + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start_held;
    (sda_oe && !scl_oe) [*8];
  endsequence
  a_scl_wait: assert property ($rose(scl_oe) |-> $past(scl_in))
    else $error("SCL pulled low before the line was seen high");
  a_scl_high: assert property ($rose(scl_oe) |-> hi_q >= baud_q)
    else $error("SCL high time shorter than one baud period");
  a_scl_low: assert property ($fell(scl_oe) |-> lo_q >= baud_q)
    else $error("SCL low time shorter than one baud period");
  a_sda_steady: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("SDA released while SCL high");
  a_start_lead: assert property ($rose(sda_oe) && scl_in |-> both_q >= baud_q)
    else $error("start driven before lines were high one period");
  a_start_hold: assert property ($rose(sda_oe) && scl_in |=> s_start_held)
    else $error("start not held for one period");
  a_ack_free: assert property ($fell(scl_in) && nf_q % 9 == 8 |-> ##6 !sda_oe)
    else $error("SDA not released for the acknowledge slot");
  a_halt_after: assert property ($fell(scl_in) && nf_q % 9 == 0 && nf_q != 0
    |-> ##4 (scl_oe && !sda_oe) [*3])
    else $error("SCL not held low after the ninth clock");
endmodule : i2c_master_tx_properties
bind i2c_master_tx i2c_master_tx_properties props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sda_in(sda_in), .scl_in(scl_in), .sda_oe(sda_oe), .scl_oe(scl_oe)
);
`default_nettype wire

// >>> verif/i2c_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  input  wire logic       sda,
  input  wire logic       scl,
  input  wire logic       nack,
  input  wire logic       stretch,
  output var  logic       sda_oe,
  output var  logic       scl_oe,
  output var  logic [7:0] rx_byte
);
  int cnt = 0;
  initial begin
    sda_oe  = 1'b0;
    scl_oe  = 1'b0;
    rx_byte = 8'h00;
  end
  // A fall of SDA while SCL is high restarts the bit count
  always @(negedge sda)
    if (scl)
      cnt = 0;
  // Bits are taken while SCL is high; the acknowledge slot is skipped
  always @(posedge scl)
    if (cnt % 9 != 0)
      rx_byte = {rx_byte[6:0], sda};
  // Answer in the ninth slot; a slow peer also holds SCL low after each fall
  always @(negedge scl) begin
    cnt++;
    sda_oe = (cnt % 9 == 0) && !nack;
    if (stretch) begin
      scl_oe = 1'b1;
      #3000;
      scl_oe = 1'b0;
    end
  end
endmodule : i2c_slave_model
`default_nettype wire

// >>> verif/tb_i2c_master_start_restart_transmit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_start_restart_transmit;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, sda_oe, scl_oe, m_sda_oe, m_scl_oe;
  logic        nack = 1'b0;
  logic        stretch = 1'b0;
  logic        clk_en = 1'b1;
  logic        hold = 1'b0;
  logic [7:0]  rx_byte;
  int          errors = 0;
  int          checks_done = 0;
  // Open-drain lines with pull-ups; hold forces both low in a peer's place
  wire logic   sda = !(sda_oe | m_sda_oe | hold);
  wire logic   scl = !(scl_oe | m_scl_oe | hold);
  always #50 pclk = ~pclk;
  i2c_master_tx dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe)
  );
  i2c_slave_model peer (
    .sda(sda), .scl(scl), .nack(nack), .stretch(stretch), .sda_oe(m_sda_oe),
    .scl_oe(m_scl_oe), .rx_byte(rx_byte)
  );
  // One APB transfer; an idle edge first keeps back-to-back calls race free
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask : rdchk
  // Poll one status bit under a bound so a stuck sequence is reported
  task automatic wait_st(input int b);
    logic [31:0] q;
    int          i;
    q = 32'h0;
    for (i = 0; i < 3000 && q[b] !== 1'b1; i++)
      xfer(1'b0, i2c_tx_pkg::ADDR_STATUS, 32'h0, q);
    chk("status wait", 32'h1, {31'h0, q[b]});
  endtask : wait_st
  // One byte, with a refused second write while it shifts
  task automatic send(input logic [7:0] b, input logic n, input logic s);
    wr(i2c_tx_pkg::ADDR_STATUS, 32'h1E);
    nack    <= n;
    stretch <= s;
    wr(i2c_tx_pkg::ADDR_BUF, {24'h0, b});
    rdchk("buffer full", i2c_tx_pkg::ADDR_STATUS, 32'h1, 32'h1);
    wr(i2c_tx_pkg::ADDR_BUF, 32'h0);
    wait_st(i2c_tx_pkg::ST_EVENT);
    rdchk("full and write_collision_flag", i2c_tx_pkg::ADDR_STATUS, 32'h5, 32'h4);
    chk("byte on bus", {24'h0, b}, {24'h0, rx_byte});
    rdchk("ack status", i2c_tx_pkg::ADDR_CTRL, 32'h40, {25'h0, n, 6'h0});
  endtask : send
  task automatic test_done;
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("baud", i2c_tx_pkg::ADDR_BAUD, 32'hFF, {24'h0, i2c_tx_pkg::BAUD_RESET});
    rdchk("unmapped", 12'h010, 32'hFFFFFFFF, 32'h0);
    wr(i2c_tx_pkg::ADDR_CTRL, 32'h1);
    wr(i2c_tx_pkg::ADDR_BUF, 32'hA5);
    wr(i2c_tx_pkg::ADDR_CTRL, 32'h2);
    wait_st(i2c_tx_pkg::ST_EVENT);
    rdchk("start flags", i2c_tx_pkg::ADDR_STATUS, 32'h6, 32'h6);
    rdchk("start ctrl", i2c_tx_pkg::ADDR_CTRL, 32'h3, 32'h0);
    send(8'hA4, 1'b0, 1'b0);
    send(8'h3C, 1'b1, 1'b1);
    stretch <= 1'b0;
    wr(i2c_tx_pkg::ADDR_STATUS, 32'h1E);
    wr(i2c_tx_pkg::ADDR_CTRL, 32'h2);
    wait_st(i2c_tx_pkg::ST_EVENT);
    rdchk("restart flags", i2c_tx_pkg::ADDR_STATUS, 32'h2, 32'h2);
    rdchk("restart ctrl", i2c_tx_pkg::ADDR_CTRL, 32'h2, 32'h0);
    send(8'h5B, 1'b0, 1'b0);
    wr(i2c_tx_pkg::ADDR_BAUD, 32'h0C);
    rdchk("baud", i2c_tx_pkg::ADDR_BAUD, 32'hFF, 32'h0C);
    // A write with the clock enable low must leave state untouched
    clk_en <= 1'b0;
    wr(i2c_tx_pkg::ADDR_BAUD, 32'h33);
    clk_en <= 1'b1;
    rdchk("frozen baud", i2c_tx_pkg::ADDR_BAUD, 32'hFF, 32'h0C);
    hold <= 1'b1;
    wr(i2c_tx_pkg::ADDR_CTRL, 32'h1);
    wait_st(i2c_tx_pkg::ST_BCOL);
    rdchk("start aborted", i2c_tx_pkg::ADDR_CTRL, 32'h1, 32'h0);
    hold <= 1'b0;
    test_done();
  end
  // Watchdog: the whole run needs well under this span
  initial begin
    #2_000_000;
    errors++;
    test_done();
  end
endmodule : tb_i2c_master_start_restart_transmit
`default_nettype wire
